// *** core/tcs_pkg.sv ***
// Shared constants and types of the trip circuit supervisor.
package tcs_pkg;

  // Timing.
  localparam int CLK_HZ         = 125_000_000;
  localparam int SAMPLE_MS      = 500;
  localparam int TICK_CYC_DEF   = (CLK_HZ / 1000) * SAMPLE_MS;
  localparam int TICKS_PER_SEC  = 1000 / SAMPLE_MS;
  localparam int CNT_W          = 6;
  localparam logic [CNT_W-1:0] TWO_IN_SAMPLES = 6'h03;

  // Alarm delay in seconds for one-input mode.
  localparam logic [4:0] DELAY_MIN = 5'h01;
  localparam logic [4:0] DELAY_MAX = 5'h1E;
  localparam logic [4:0] DELAY_RST = 5'h02;

  // Sense pair coding, contact bit then breaker bit, low means activated.
  localparam logic [1:0] PAIR_OPEN_ON    = 2'h2;
  localparam logic [1:0] PAIR_OPEN_OFF   = 2'h3;
  localparam logic [1:0] PAIR_CLOSED_ON  = 2'h0;
  localparam logic [1:0] PAIR_CLOSED_OFF = 2'h1;

  localparam int NUM_CIRC = 3;

  // Register word offsets.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DELAY  = 8'h04;
  localparam logic [7:0] OFS_ROUTE  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_ISTAT  = 8'h10;
  localparam logic [7:0] OFS_IMASK  = 8'h14;

  // Control fields and reset values.
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_NUM_LSB  = 1;
  localparam int CTRL_TWO_LSB  = 4;
  localparam logic       EN_RST    = 1'b0;
  localparam logic [1:0] NUM_RST   = 2'h3;
  localparam logic [2:0] TWO_RST   = 3'h7;
  localparam logic [5:0] ROUTE_RST = 6'h3F;

  // Status fields.
  localparam int STAT_FAIL_LSB = 1;
  localparam int STAT_CFG_LSB  = 4;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tcs_wbreq_type;

endpackage

// *** core/tcs_circuit.sv ***
// One supervised trip circuit: input synchroniser, sample qualification and alarm.
`timescale 1ns/1ps
module tcs_circuit
  import tcs_pkg::*;
(
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Control from the supervisor.
  input  wire logic             tick,
  input  wire logic             active,
  input  wire logic             twoInput,
  input  wire logic             sysFault,
  input  wire logic [CNT_W-1:0] delayTicks,
  // Sense pins.
  input  wire logic             contactPin,
  input  wire logic             breakerPin,
  // Result.
  output logic                  failAlarm
);

  logic             contactMeta_r, contactMeta_nxt;
  logic             contactSync_r, contactSync_nxt;
  logic             breakerMeta_r, breakerMeta_nxt;
  logic             breakerSync_r, breakerSync_nxt;
  logic [CNT_W-1:0] badCnt_r, badCnt_nxt;
  logic [CNT_W-1:0] goodCnt_r, goodCnt_nxt;
  logic             failAlarm_r, failAlarm_nxt;
  logic [CNT_W-1:0] need;
  logic             abnormal;

  always_comb
  begin
    contactMeta_nxt = contactPin;
    contactSync_nxt = contactMeta_r;
    breakerMeta_nxt = breakerPin;
    breakerSync_nxt = breakerMeta_r;
    badCnt_nxt      = badCnt_r;
    goodCnt_nxt     = goodCnt_r;
    failAlarm_nxt   = failAlarm_r;
    need            = twoInput ? TWO_IN_SAMPLES : delayTicks;
    if (twoInput)
      abnormal = ({contactSync_r, breakerSync_r} == PAIR_CLOSED_ON);
    else
      abnormal = !contactSync_r;
    if (!active)
    begin
      badCnt_nxt    = '0;
      goodCnt_nxt   = '0;
      failAlarm_nxt = 1'b0;
    end
    else if (tick)
    begin
      if (sysFault)
      begin
        // A trip during a system fault must not count toward an alarm.
        badCnt_nxt = '0;
      end
      else if (abnormal)
      begin
        goodCnt_nxt = '0;
        if (badCnt_r < need)
          badCnt_nxt = badCnt_r + 6'h01;
        if (badCnt_r + 6'h01 >= need)
          failAlarm_nxt = 1'b1;
      end
      else
      begin
        badCnt_nxt = '0;
        if (goodCnt_r < need)
          goodCnt_nxt = goodCnt_r + 6'h01;
        if (goodCnt_r + 6'h01 >= need)
          failAlarm_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      contactMeta_r <= 1'b1;
      contactSync_r <= 1'b1;
      breakerMeta_r <= 1'b1;
      breakerSync_r <= 1'b1;
      badCnt_r      <= '0;
      goodCnt_r     <= '0;
      failAlarm_r   <= 1'b0;
    end
    else
    begin
      contactMeta_r <= contactMeta_nxt;
      contactSync_r <= contactSync_nxt;
      breakerMeta_r <= breakerMeta_nxt;
      breakerSync_r <= breakerSync_nxt;
      badCnt_r      <= badCnt_nxt;
      goodCnt_r     <= goodCnt_nxt;
      failAlarm_r   <= failAlarm_nxt;
    end
  end

  assign failAlarm = failAlarm_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_alarm_cause: assert property ($rose(failAlarm_r) |-> $past(active && tick && abnormal && !sysFault))
    else $error("Alarm rose without a qualifying abnormal sample.");
  a_two_three: assert property ($rose(failAlarm_r) && $past(twoInput) |-> $past(badCnt_r) == 6'h02)
    else $error("Two-input alarm rose before three abnormal samples.");
  a_idle_clear: assert property (!active |=> !failAlarm_r && badCnt_r == 6'h00)
    else $error("Counters or alarm not cleared while inactive.");
  a_fault_block: assert property (active && tick && sysFault |=> badCnt_r == 6'h00 && !$rose(failAlarm_r))
    else $error("Sample counted during a system fault.");
  a_auto_reset: assert property ($fell(failAlarm_r) && $past(active) |-> $past(tick && !abnormal))
    else $error("Alarm dropped without a normal sample.");

endmodule

// *** core/tcs_supervisor.sv ***
// Trip circuit supervisor top: tick, registers over Wishbone, interrupts and three circuits.
`timescale 1ns/1ps
module tcs_supervisor
  import tcs_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DEF
)
(
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                rst_b,
  // Wishbone slave.
  input  wire tcs_wbreq_type       wbReq,
  output logic [31:0]              wbRdDat,
  output logic                     wbAck,
  // Sense pins and system fault.
  input  wire logic [NUM_CIRC-1:0] contactSense,
  input  wire logic [NUM_CIRC-1:0] breakerSense,
  input  wire logic                sysFaultPin,
  // Indications.
  output logic [NUM_CIRC-1:0]      failAlarm,
  output logic [NUM_CIRC-1:0]      circuitConfigFailAlarm,
  output logic                     supervisionOffIndication,
  output logic                     irq
);

  localparam int TW = $clog2(TICK_CYC);

  // Bus and register state.
  logic                ack_r, ack_nxt;
  logic [31:0]         dat_r, dat_nxt;
  logic                enable_r, enable_nxt;
  logic [1:0]          numCirc_r, numCirc_nxt;
  logic [2:0]          twoIn_r, twoIn_nxt;
  logic [4:0]          delay_r, delay_nxt;
  logic [5:0]          route_r, route_nxt;
  logic [5:0]          iStat_r, iStat_nxt;
  logic [5:0]          iMask_r, iMask_nxt;
  logic                irq_r, irq_nxt;
  // Supervision state.
  logic [TW-1:0]       tickCnt_r, tickCnt_nxt;
  logic                tick_r, tick_nxt;
  logic                faultMeta_r, faultMeta_nxt;
  logic                faultSync_r, faultSync_nxt;
  logic [2:0]          cfgFail_r, cfgFail_nxt;
  logic                off_r, off_nxt;
  logic [2:0]          failPrev_r, failPrev_nxt;
  logic [2:0]          cfgPrev_r, cfgPrev_nxt;
  logic [2:0]          inUse;
  logic [2:0]          active;
  logic [2:0]          failInt;
  logic [CNT_W-1:0]    delayTicks;
  logic                req;
  logic                wr;
  logic [4:0]          wDelay;

  // A request is taken only while ack is low, so a strobe held through the ack cycle is not answered twice.
  assign req = wbReq.cyc && wbReq.stb && !ack_r;
  assign wr  = req && wbReq.we && wbReq.sel[0];
  assign delayTicks = CNT_W'({1'b0, delay_r} * TICKS_PER_SEC);

  // Register file and bus answer.
  always_comb
  begin
    ack_nxt     = req;
    dat_nxt     = '0;
    enable_nxt  = enable_r;
    numCirc_nxt = numCirc_r;
    twoIn_nxt   = twoIn_r;
    delay_nxt   = delay_r;
    route_nxt   = route_r;
    iMask_nxt   = iMask_r;
    wDelay      = wbReq.dat[4:0];
    // Set wins over a write-one clear in the same cycle.
    iStat_nxt = iStat_r | {cfgFail_r & ~cfgPrev_r, failInt & ~failPrev_r};
    if (wr)
    begin
      case (wbReq.adr)
        OFS_CTRL:
        begin
          enable_nxt  = wbReq.dat[CTRL_EN_BIT];
          numCirc_nxt = wbReq.dat[CTRL_NUM_LSB +: 2];
          twoIn_nxt   = wbReq.dat[CTRL_TWO_LSB +: 3];
        end
        OFS_DELAY:
        begin
          // Out-of-range delays are clamped rather than refused, so a read shows what is in force.
          if (wDelay < DELAY_MIN)
            delay_nxt = DELAY_MIN;
          else if (wDelay > DELAY_MAX)
            delay_nxt = DELAY_MAX;
          else
            delay_nxt = wDelay;
        end
        OFS_ROUTE: route_nxt = wbReq.dat[5:0];
        OFS_ISTAT: iStat_nxt = (iStat_r & ~wbReq.dat[5:0]) | {cfgFail_r & ~cfgPrev_r, failInt & ~failPrev_r};
        OFS_IMASK: iMask_nxt = wbReq.dat[5:0];
        default: ;
      endcase
    end
    if (req && !wbReq.we)
    begin
      case (wbReq.adr)
        OFS_CTRL:   dat_nxt = {25'h0, twoIn_r, 1'b0, numCirc_r, enable_r};
        OFS_DELAY:  dat_nxt = {27'h0, delay_r};
        OFS_ROUTE:  dat_nxt = {26'h0, route_r};
        OFS_STATUS: dat_nxt = {25'h0, cfgFail_r, failInt, off_r};
        OFS_ISTAT:  dat_nxt = {26'h0, iStat_r};
        OFS_IMASK:  dat_nxt = {26'h0, iMask_r};
        default:    dat_nxt = '0;
      endcase
    end
    irq_nxt = |(iStat_r & iMask_r);
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_r     <= 1'b0;
      dat_r     <= '0;
      enable_r  <= EN_RST;
      numCirc_r <= NUM_RST;
      twoIn_r   <= TWO_RST;
      delay_r   <= DELAY_RST;
      route_r   <= ROUTE_RST;
      iStat_r   <= '0;
      iMask_r   <= '0;
      irq_r     <= 1'b0;
    end
    else
    begin
      ack_r     <= ack_nxt;
      dat_r     <= dat_nxt;
      enable_r  <= enable_nxt;
      numCirc_r <= numCirc_nxt;
      twoIn_r   <= twoIn_nxt;
      delay_r   <= delay_nxt;
      route_r   <= route_nxt;
      iStat_r   <= iStat_nxt;
      iMask_r   <= iMask_nxt;
      irq_r     <= irq_nxt;
    end
  end

  // Tick, fault synchroniser, configuration check and off indication.
  always_comb
  begin
    faultMeta_nxt = sysFaultPin;
    faultSync_nxt = faultMeta_r;
    failPrev_nxt  = failInt;
    cfgPrev_nxt   = cfgFail_r;
    tickCnt_nxt   = '0;
    tick_nxt      = 1'b0;
    off_nxt       = !enable_r;
    cfgFail_nxt   = '0;
    if (enable_r)
    begin
      if (tickCnt_r == TW'(TICK_CYC - 1))
        tick_nxt = 1'b1;
      else
        tickCnt_nxt = tickCnt_r + TW'(1);
      for (int i = 0; i < NUM_CIRC; i++)
      begin
        // One input needs the contact sense routed and the breaker sense not routed, two need both.
        if (inUse[i])
          cfgFail_nxt[i] = !route_r[i] || (twoIn_r[i] != route_r[i+3]);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tickCnt_r   <= '0;
      tick_r      <= 1'b0;
      faultMeta_r <= 1'b0;
      faultSync_r <= 1'b0;
      cfgFail_r   <= '0;
      off_r       <= 1'b1;
      failPrev_r  <= '0;
      cfgPrev_r   <= '0;
    end
    else
    begin
      tickCnt_r   <= tickCnt_nxt;
      tick_r      <= tick_nxt;
      faultMeta_r <= faultMeta_nxt;
      faultSync_r <= faultSync_nxt;
      cfgFail_r   <= cfgFail_nxt;
      off_r       <= off_nxt;
      failPrev_r  <= failPrev_nxt;
      cfgPrev_r   <= cfgPrev_nxt;
    end
  end

  // Each circuit is gated here, so an unused or misrouted one never raises an alarm.
  genvar g;
  generate
    for (g = 0; g < NUM_CIRC; g++)
    begin : gCirc
      assign inUse[g]  = (numCirc_r > 2'(g));
      assign active[g] = enable_r && inUse[g] && !cfgFail_r[g];
      tcs_circuit uCirc (
        .clk        (clk),
        .rst_b      (rst_b),
        .tick       (tick_r),
        .active     (active[g]),
        .twoInput   (twoIn_r[g]),
        .sysFault   (faultSync_r),
        .delayTicks (delayTicks),
        .contactPin (contactSense[g]),
        .breakerPin (breakerSense[g]),
        .failAlarm  (failInt[g])
      );
    end
  endgenerate

  assign wbAck                    = ack_r;
  assign wbRdDat                  = dat_r;
  assign failAlarm                = failInt;
  assign circuitConfigFailAlarm   = cfgFail_r;
  assign supervisionOffIndication = off_r;
  assign irq                      = irq_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_req;
    wbReq.cyc && wbReq.stb && !ack_r;
  endsequence
  sequence s_ans;
    ack_r ##1 !ack_r;
  endsequence

  a_bus_answer: assert property (s_req |=> s_ans)
    else $error("Bus request not answered with a one-cycle ack.");
  a_off_show: assert property (!enable_r |=> off_r && failInt == 3'h0)
    else $error("Off indication or alarm wrong while disabled.");
  a_cfg_block: assert property (cfgFail_r[0] |=> !failInt[0])
    else $error("Circuit supervised despite configuration failure.");
  a_none_used: assert property (numCirc_r == 2'h0 |=> ##1 cfgFail_r == 3'h0 && failInt == 3'h0)
    else $error("Circuit monitored while supervision removed.");
  a_irq_level: assert property (|(iStat_r & iMask_r) |=> irq_r)
    else $error("Interrupt low with an unmasked status bit.");
  a_tick_rate: assert property (tick_r |=> !tick_r)
    else $error("Sample tick lasted more than one cycle.");

  // Register side: answers, writes, clamping and the interrupt level.
  a_ack_idle: assert property (!ack_r |-> dat_r == 32'h0)
    else $error("Read data not zero outside an acknowledge.");
  a_ctrl_write: assert property (wr && wbReq.adr == OFS_CTRL
    |=> enable_r == $past(wbReq.dat[CTRL_EN_BIT]))
    else $error("Control write did not reach the enable bit.");
  a_route_write: assert property (wr && wbReq.adr == OFS_ROUTE
    |=> route_r == $past(wbReq.dat[5:0]))
    else $error("Routing write did not land.");
  a_mask_write: assert property (wr && wbReq.adr == OFS_IMASK |=> iMask_r == $past(wbReq.dat[5:0]))
    else $error("Mask write did not land.");
  a_delay_read: assert property (s_req && !wbReq.we && wbReq.adr == OFS_DELAY
    |=> dat_r == {27'h0, $past(delay_r)})
    else $error("Delay register read back wrong.");
  a_hole_read: assert property (s_req && !wbReq.we && wbReq.adr > OFS_IMASK
    |=> dat_r == 32'h0)
    else $error("Unmapped address read back non-zero.");
  a_delay_range: assert property (delay_r >= DELAY_MIN && delay_r <= DELAY_MAX)
    else $error("Alarm delay outside its settable range.");
  a_irq_quiet: assert property (!(|(iStat_r & iMask_r)) |=> !irq_r)
    else $error("Interrupt high with no unmasked status bit.");

  // A rising alarm is latched on the next edge even when software clears the same bit then.
  a_fail_latch: assert property ((failInt & ~failPrev_r) != 3'h0
    |=> (iStat_r[2:0] & $past(failInt & ~failPrev_r)) == $past(failInt & ~failPrev_r))
    else $error("Alarm rise not latched in the interrupt status.");
  a_cfg_latch: assert property ((cfgFail_r & ~cfgPrev_r) != 3'h0
    |=> (iStat_r[5:3] & $past(cfgFail_r & ~cfgPrev_r)) == $past(cfgFail_r & ~cfgPrev_r))
    else $error("Config alarm rise not latched in the interrupt status.");

  // Disabling must leave no tick and no config alarm; enabling must clear the off indication.
  a_tick_off: assert property (!enable_r |=> !tick_r && tickCnt_r == '0)
    else $error("Tick still running while disabled.");
  a_cfg_off: assert property (!enable_r |=> cfgFail_r == 3'h0)
    else $error("Config alarm held while disabled.");
  a_off_clear: assert property (enable_r |=> !off_r)
    else $error("Off indication shown while enabled.");

endmodule

// *** bench/tcs_contact_model.sv ***
// Behavioural model of the trip contacts and breaker auxiliary sensing of three circuits.
`timescale 1ns/1ps
module tcs_contact_model
  import tcs_pkg::*;
(
  // Circuit state set by the bench.
  input  wire logic [NUM_CIRC-1:0] tripClosed,
  input  wire logic [NUM_CIRC-1:0] bkrOn,
  input  wire logic [NUM_CIRC-1:0] broken,
  // Sense pins towards the supervisor.
  output logic      [NUM_CIRC-1:0] contactSense,
  output logic      [NUM_CIRC-1:0] breakerSense
);
  // A closed contact shorts its input; an interrupted circuit leaves both inputs dead, as a real break would.
  assign contactSense = ~tripClosed & ~broken;
  assign breakerSense = ~bkrOn & ~broken;
endmodule

// *** bench/tb.sv ***
// Self-checking testbench of the trip circuit supervisor.
`timescale 1ns/1ps
module tb;
  import tcs_pkg::*;
  localparam int TK = 8;
  typedef struct packed
  {
    logic [7:0] ctrl;
    logic [5:0] route;
    logic [2:0] cfg;
  } tcs_row_type;
  // Control and routing pairs beside the config alarms that they should give.
  localparam tcs_row_type ROWS [8] = '{
    '{8'h77, 6'h3F, 3'h0}, '{8'h77, 6'h07, 3'h7}, '{8'h07, 6'h07, 3'h0}, '{8'h07, 6'h3F, 3'h7},
    '{8'h77, 6'h3D, 3'h2}, '{8'h53, 6'h00, 3'h1}, '{8'h71, 6'h00, 3'h0}, '{8'h75, 6'h1B, 3'h0}};

  logic                clk;
  logic                rstB;
  tcs_wbreq_type       wbReq;
  logic [31:0]         wbRdDat;
  logic                wbAck;
  logic [NUM_CIRC-1:0] contactSense;
  logic [NUM_CIRC-1:0] breakerSense;
  logic                sysFaultPin;
  logic [NUM_CIRC-1:0] failAlarm;
  logic [NUM_CIRC-1:0] cfgAlarm;
  logic                offInd;
  logic                irq;
  logic [NUM_CIRC-1:0] tripClosed;
  logic [NUM_CIRC-1:0] bkrOn;
  logic [NUM_CIRC-1:0] broken;
  int                  badCount;
  int                  testsRun;

  tcs_supervisor #(.TICK_CYC(TK)) dut_u (
    .clk                      (clk),
    .rst_b                    (rstB),
    .wbReq                    (wbReq),
    .wbRdDat                  (wbRdDat),
    .wbAck                    (wbAck),
    .contactSense             (contactSense),
    .breakerSense             (breakerSense),
    .sysFaultPin              (sysFaultPin),
    .failAlarm                (failAlarm),
    .circuitConfigFailAlarm   (cfgAlarm),
    .supervisionOffIndication (offInd),
    .irq                      (irq)
  );

  tcs_contact_model model_u (
    .tripClosed   (tripClosed),
    .bkrOn        (bkrOn),
    .broken       (broken),
    .contactSense (contactSense),
    .breakerSense (breakerSense)
  );

  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  task automatic results();
    if (badCount == 0 && testsRun > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      badCount++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // The request is held until ack is sampled, giving the slave up to 19 edges to answer before the bench fails.
  task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    wbReq <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: adr, sel: 4'hF, dat: dat};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wbAck !== 1'h1 && n < 20);
    rd = wbRdDat;
    wbReq <= '0;
    if (n >= 20)
    begin
      badCount++;
      results();
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] rd;
    wbXfer(1'h1, adr, dat, rd);
  endtask

  task automatic rdChk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] rd;
    wbXfer(1'h0, adr, 32'h0, rd);
    chk(rd, exp);
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge clk);
  endtask

  // Counts edges until the alarm reaches the level and checks the count lies in the window.
  task automatic waitAlarm(input int idx, input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (failAlarm[idx] !== lvl && n <= hi)
    begin
      @(posedge clk);
      n++;
    end
    chk(32'(n), (n >= lo && n <= hi) ? 32'(n) : 32'(lo));
    if (n > hi)
      results();
  endtask

  initial
  begin
    rstB = 1'h0;
    wbReq = '0;
    sysFaultPin = 1'h0;
    tripClosed = 3'h0;
    bkrOn = 3'h7;
    broken = 3'h0;
    badCount = 0;
    testsRun = 0;
    idle(20);
    rstB <= 1'h1;
    chk({31'h0, offInd}, 32'h1);
    rdChk(OFS_CTRL, 32'h76);
    rdChk(OFS_DELAY, 32'h2);
    rdChk(OFS_STATUS, 32'h1);
    rdChk(OFS_IMASK, 32'h0);
    rdChk(8'h18, 32'h0);
    foreach (ROWS[i])
    begin
      wr(OFS_ROUTE, {26'h0, ROWS[i].route});
      wr(OFS_CTRL, {24'h0, ROWS[i].ctrl});
      idle(4);
      chk({29'h0, cfgAlarm}, {29'h0, ROWS[i].cfg});
    end
    wr(OFS_ROUTE, 32'h3F);
    wr(OFS_CTRL, 32'h77);
    wr(OFS_IMASK, 32'h07);
    wr(OFS_ISTAT, 32'h3F);
    // Open/off, closed/off and open/on are healthy pairs.
    for (int s = 0; s < 3; s++)
    begin
      tripClosed[1] <= (s == 1);
      bkrOn[1] <= (s == 2);
      idle(5 * TK);
      chk({29'h0, failAlarm}, 32'h0);
    end
    tripClosed[1] <= 1'h1;
    waitAlarm(1, 1'h1, 2 * TK + 4, 3 * TK + 3);
    idle(3);
    chk({31'h0, irq}, 32'h1);
    rdChk(OFS_ISTAT, 32'h2);
    wr(OFS_ISTAT, 32'h2);
    idle(3);
    chk({31'h0, irq}, 32'h0);
    rdChk(OFS_STATUS, 32'h4);
    tripClosed[1] <= 1'h0;
    waitAlarm(1, 1'h0, 2 * TK + 4, 3 * TK + 3);
    sysFaultPin <= 1'h1;
    broken[0] <= 1'h1;
    idle(6 * TK);
    chk({29'h0, failAlarm}, 32'h0);
    sysFaultPin <= 1'h0;
    waitAlarm(0, 1'h1, 2 * TK + 4, 3 * TK + 3);
    broken[0] <= 1'h0;
    waitAlarm(0, 1'h0, 2 * TK + 4, 3 * TK + 3);
    // Two-input circuits without a routed breaker input are blocked.
    wr(OFS_ROUTE, 32'h07);
    broken[0] <= 1'h1;
    idle(5 * TK);
    chk({29'h0, failAlarm}, 32'h0);
    chk({29'h0, cfgAlarm}, 32'h7);
    broken[0] <= 1'h0;
    wr(OFS_CTRL, 32'h07);
    wr(OFS_DELAY, 32'h00);
    rdChk(OFS_DELAY, 32'h01);
    wr(OFS_DELAY, 32'hFF);
    rdChk(OFS_DELAY, 32'h1E);
    wr(OFS_DELAY, 32'h01);
    wr(OFS_IMASK, 32'h00);
    idle(4);
    chk({29'h0, cfgAlarm}, 32'h0);
    broken[2] <= 1'h1;
    waitAlarm(2, 1'h1, TK + 4, 2 * TK + 3);
    chk({31'h0, irq}, 32'h0);
    broken[2] <= 1'h0;
    waitAlarm(2, 1'h0, TK + 4, 2 * TK + 3);
    broken[2] <= 1'h1;
    waitAlarm(2, 1'h1, TK + 4, 2 * TK + 3);
    wr(OFS_CTRL, 32'h06);
    idle(3);
    chk({29'h0, failAlarm}, 32'h0);
    chk({31'h0, offInd}, 32'h1);
    results();
  end
endmodule
